// ### design/aegc_consts.vh
`ifndef AEGC_CONSTS_VH
`define AEGC_CONSTS_VH
// Register byte addresses
`define AEGC_A_CTRL     6'h00
`define AEGC_A_START    6'h04
`define AEGC_A_WIDTH    6'h08
`define AEGC_A_LINES    6'h0C
`define AEGC_A_SELECT   6'h10
`define AEGC_A_GAIN     6'h14
`define AEGC_A_GMIN     6'h18
`define AEGC_A_GMAX     6'h1C
`define AEGC_A_TARGET   6'h20
`define AEGC_A_EXP      6'h24
`define AEGC_A_EMIN     6'h28
`define AEGC_A_EMAX     6'h2C
`define AEGC_A_IMSTART  6'h30
`define AEGC_A_IMWIDTH  6'h34
`define AEGC_A_STATUS   6'h38
`define AEGC_A_LASTCNT  6'h3C
// Control word fields
`define AEGC_F_GMODE    1:0
`define AEGC_F_EMODE    3:2
`define AEGC_B_PIX12    4
`define AEGC_F_BIN      6:5
`define AEGC_B_TRIGW    7
`define AEGC_F_TAP      9:8
`define AEGC_B_PROFILE  10
`define AEGC_B_LIMOFF   11
// Loop modes
`define AEGC_MODE_OFF   2'h0
`define AEGC_MODE_ONCE  2'h1
`define AEGC_MODE_CONT  2'h2
// Gain taps and binning off value
`define AEGC_TAP_ANALOG 2'h0
`define AEGC_TAP_ALLDIG 2'h1
`define AEGC_BIN_OFF    2'h0
// Reset values
`define AEGC_RST_START  13'h0000
`define AEGC_RST_LINES  16'h0080
`define AEGC_RST_SELECT 2'h1
`define AEGC_RST_TARGET 12'h080
// Target bounds per pixel format
`define AEGC_T8_MIN     12'h032
`define AEGC_T8_MAX     12'h0CD
`define AEGC_T12_MIN    12'h320
`define AEGC_T12_MAX    12'hCD0
// Once mode attempt limit
`define AEGC_MAX_TRIES  5'h1E
`endif

// ### design/aegc_stats.v
`timescale 1ns/10ps
`default_nettype none
module aegc_stats #(
  parameter X_W     = 13,
  parameter LINES_W = 16,
  parameter SUM_W   = 40,
  parameter CNT_W   = 29
) (
  input  wire               ref_clk,
  input  wire               rst_n,
  input  wire               en,
  input  wire               pix_valid,
  input  wire               pix_sol,
  input  wire               pix_eol,
  input  wire [11:0]        pix_data,
  input  wire               acq_end,
  input  wire [X_W:0]       win_lo,
  input  wire [X_W:0]       win_hi,
  input  wire [LINES_W-1:0] lines,
  output reg                done_q,
  output reg  [SUM_W-1:0]   sum_q,
  output reg  [CNT_W-1:0]   cnt_q,
  output reg  [LINES_W-1:0] used_q
);

  reg  [X_W:0]       x_q;
  reg  [LINES_W-1:0] line_q;
  reg  [SUM_W-1:0]   acc_q;
  reg  [CNT_W-1:0]   acnt_q;
  wire [X_W:0]       idx;
  wire               in_win;
  wire [SUM_W-1:0]   acc_n;
  wire [CNT_W-1:0]   acnt_n;
  wire [LINES_W-1:0] line_n;
  wire               full;
  wire               finish;

  assign idx    = pix_sol ? {(X_W+1){1'b0}} : x_q;
  assign in_win = pix_valid && (idx >= win_lo) && (idx < win_hi);
  assign acc_n  = in_win ? acc_q + {{(SUM_W-12){1'b0}}, pix_data} : acc_q;
  assign acnt_n = in_win ? acnt_q + {{(CNT_W-1){1'b0}}, 1'b1} : acnt_q;
  assign line_n = pix_eol ? line_q + {{(LINES_W-1){1'b0}}, 1'b1} : line_q;
  assign full   = pix_eol && (line_n >= lines);
  assign finish = full || (acq_end && (line_n != {LINES_W{1'b0}}));

  //////////////////////////////////////////////////////////////////////
  // Line window accumulation
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q    <= {(X_W+1){1'b0}};
      line_q <= {LINES_W{1'b0}};
      acc_q  <= {SUM_W{1'b0}};
      acnt_q <= {CNT_W{1'b0}};
      done_q <= 1'b0;
      sum_q  <= {SUM_W{1'b0}};
      cnt_q  <= {CNT_W{1'b0}};
      used_q <= {LINES_W{1'b0}};
    end else if (!en) begin
      x_q    <= {(X_W+1){1'b0}};
      line_q <= {LINES_W{1'b0}};
      acc_q  <= {SUM_W{1'b0}};
      acnt_q <= {CNT_W{1'b0}};
      done_q <= 1'b0;
    end else begin
      if (pix_valid) begin
        x_q <= idx + {{X_W{1'b0}}, 1'b1};
      end
      if (finish) begin
        done_q <= 1'b1;
        sum_q  <= acc_n;
        cnt_q  <= acnt_n;
        used_q <= line_n;
        acc_q  <= {SUM_W{1'b0}};
        acnt_q <= {CNT_W{1'b0}};
        line_q <= {LINES_W{1'b0}};
      end else begin
        done_q <= 1'b0;
        acc_q  <= acc_n;
        acnt_q <= acnt_n;
        line_q <= line_n;
      end
    end
  end

endmodule // aegc_stats
`default_nettype wire

// ### design/aegc_top.v
// The plain strobed port and the register addresses were left to the implementer.
`include "aegc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module aegc_top #(
  parameter        X_W       = 13,
  parameter        LINES_W   = 16,
  parameter        SUM_W     = 40,
  parameter        CNT_W     = 29,
  parameter        GAIN_W    = 12,
  parameter        EXP_W     = 20,
  parameter [12:0] SENSOR_W  = 13'h1000,
  parameter [11:0] GAIN_LO8  = 12'h000,
  parameter [11:0] GAIN_LO12 = 12'h000,
  parameter [11:0] GAIN_HI   = 12'h3FF,
  parameter [11:0] GAIN_HIB  = 12'h1FF,
  parameter [11:0] GAIN_HIF  = 12'hFFF,
  parameter [11:0] GAIN_STEP = 12'h001,
  parameter [19:0] EXP_MIN   = 20'h00002,
  parameter [19:0] EXP_MAX   = 20'hFFFFF,
  parameter [19:0] EXP_STEP  = 20'h00001,
  parameter [19:0] EXP_RATE  = 20'h00064,
  parameter [11:0] TOL       = 12'h002
) (
  input  wire              ref_clk,
  input  wire              rst_n,
  input  wire [5:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata_q,
  input  wire              pix_valid,
  input  wire              pix_sol,
  input  wire              pix_eol,
  input  wire [11:0]       pix_data,
  input  wire              acq_end,
  output reg  [GAIN_W-1:0] gain_value_q,
  output reg  [EXP_W-1:0]  exposure_duration_q,
  output reg               line_rate_reduce_q
);

  //////////////////////////////////////////////////////////////////////
  // Helpers
  function [X_W:0] fmax;
    input [X_W:0] a;
    input [X_W:0] b;
    begin
      fmax = (a > b) ? a : b;
    end
  endfunction

  function [X_W:0] fmin;
    input [X_W:0] a;
    input [X_W:0] b;
    begin
      fmin = (a < b) ? a : b;
    end
  endfunction

  function [31:0] fclamp;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      fclamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [SUM_W-1:0] fmul;
    input [11:0]      t;
    input [CNT_W-1:0] c;
    begin
      fmul = {{(SUM_W-12){1'b0}}, t} * {{(SUM_W-CNT_W){1'b0}}, c};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Registers
  reg  [1:0]         gain_loop_mode_q;
  reg  [1:0]         exposure_loop_mode_q;
  reg                pix12_q;
  reg  [1:0]         binning_q;
  reg                trig_width_q;
  reg  [1:0]         gain_tap_select_q;
  reg                profile_q;
  reg                lim_off_q;
  reg  [X_W-1:0]     stats_region_start_q;
  reg  [X_W-1:0]     stats_region_width_q;
  reg  [LINES_W-1:0] stats_region_lines_q;
  reg  [1:0]         stats_region_select_q;
  reg  [X_W-1:0]     image_start_q;
  reg  [X_W-1:0]     image_width_q;
  reg  [GAIN_W-1:0]  auto_gain_min_q;
  reg  [GAIN_W-1:0]  auto_gain_max_q;
  reg  [11:0]        target_gray_level_q;
  reg  [EXP_W-1:0]   auto_exposure_min_q;
  reg  [EXP_W-1:0]   auto_exposure_max_q;
  reg  [4:0]         gain_tries_q;
  reg  [4:0]         exp_tries_q;
  reg                gain_hit_q;
  reg                exp_hit_q;

  wire [31:0]        wd;
  wire [X_W:0]       ov_lo;
  wire [X_W:0]       ov_hi;
  wire               overlap;
  wire               gain_act;
  wire               exp_act;
  wire               st_done;
  wire [SUM_W-1:0]   st_sum;
  wire [CNT_W-1:0]   st_cnt;
  wire [LINES_W-1:0] st_used;
  wire [11:0]        tgt_lo;
  wire [11:0]        tgt_hi;
  wire [11:0]        g_lim_lo;
  wire [11:0]        g_lim_hi;
  wire [SUM_W-1:0]   want_lo;
  wire [SUM_W-1:0]   want_hi;
  wire               upd;
  wire               dark;
  wire               bright;
  wire               hit;
  wire               g_can;
  wire               e_can;
  wire               pref_g;
  wire               use_g;
  wire               use_e;
  wire [GAIN_W:0]    g_up;
  wire [GAIN_W-1:0]  g_new;
  wire [EXP_W:0]     e_up;
  wire [EXP_W-1:0]   e_new;
  wire               w_ctrl;
  wire [31:0]        c_gain;
  wire [31:0]        c_tgt;
  wire [31:0]        c_exp;

  assign wd = reg_wdata;

  // Image window and overlap in delivered (binned) pixels
  assign ov_lo = fmax({1'b0, stats_region_start_q},
                      {1'b0, image_start_q});
  assign ov_hi = fmin({1'b0, stats_region_start_q} + {1'b0, stats_region_width_q},
                      {1'b0, image_start_q} + {1'b0, image_width_q});
  assign overlap = ov_hi > ov_lo;

  assign gain_act = (gain_loop_mode_q != `AEGC_MODE_OFF) && overlap &&
                    (gain_tap_select_q == `AEGC_TAP_ALLDIG);
  assign exp_act  = (exposure_loop_mode_q != `AEGC_MODE_OFF) && overlap &&
                    !trig_width_q;

  // Target and gain bound ranges
  assign tgt_lo = pix12_q ? `AEGC_T12_MIN : `AEGC_T8_MIN;
  assign tgt_hi = pix12_q ? `AEGC_T12_MAX : `AEGC_T8_MAX;
  assign g_lim_lo = lim_off_q ? 12'h000 : (pix12_q ? GAIN_LO12 : GAIN_LO8);
  assign g_lim_hi = lim_off_q ? GAIN_HIF :
                    ((binning_q != `AEGC_BIN_OFF) ? GAIN_HIB : GAIN_HI);

  //////////////////////////////////////////////////////////////////////
  // Statistics
  aegc_stats #(
    .X_W     (X_W),
    .LINES_W (LINES_W),
    .SUM_W   (SUM_W),
    .CNT_W   (CNT_W)
  ) u_stats (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .en        (gain_act | exp_act),
    .pix_valid (pix_valid),
    .pix_sol   (pix_sol),
    .pix_eol   (pix_eol),
    .pix_data  (pix_data),
    .acq_end   (acq_end),
    .win_lo    (ov_lo),
    .win_hi    (ov_hi),
    .lines     (stats_region_lines_q),
    .done_q    (st_done),
    .sum_q     (st_sum),
    .cnt_q     (st_cnt),
    .used_q    (st_used)
  );

  //////////////////////////////////////////////////////////////////////
  // Decision
  assign want_lo = fmul(target_gray_level_q - TOL, st_cnt);
  assign want_hi = fmul(target_gray_level_q + TOL, st_cnt);
  assign upd     = st_done && (st_cnt != {CNT_W{1'b0}});
  assign dark    = st_sum < want_lo;
  assign bright  = st_sum > want_hi;
  assign hit     = !dark && !bright;

  assign g_can  = dark ? (gain_value_q < auto_gain_max_q) :
                         (gain_value_q > auto_gain_min_q);
  assign e_can  = dark ? (exposure_duration_q < auto_exposure_max_q) :
                         (exposure_duration_q > auto_exposure_min_q);
  assign pref_g = dark ? !profile_q : profile_q;
  assign use_g  = upd && !hit && gain_act && g_can &&
                  (!exp_act || !e_can || pref_g);
  assign use_e  = upd && !hit && exp_act && e_can && !use_g;

  assign g_up  = {1'b0, gain_value_q} + {1'b0, GAIN_STEP};
  assign g_new = dark ?
    ((g_up > {1'b0, auto_gain_max_q}) ? auto_gain_max_q : g_up[GAIN_W-1:0]) :
    ((gain_value_q < auto_gain_min_q + GAIN_STEP) ? auto_gain_min_q :
      gain_value_q - GAIN_STEP);
  assign e_up  = {1'b0, exposure_duration_q} + {1'b0, EXP_STEP};
  assign e_new = dark ?
    ((e_up > {1'b0, auto_exposure_max_q}) ? auto_exposure_max_q : e_up[EXP_W-1:0]) :
    ((exposure_duration_q < auto_exposure_min_q + EXP_STEP) ? auto_exposure_min_q :
      exposure_duration_q - EXP_STEP);

  assign w_ctrl = reg_wr && (reg_addr == `AEGC_A_CTRL);
  assign c_gain = fclamp({20'h00000, wd[11:0]}, {20'h00000, g_lim_lo}, {20'h00000, g_lim_hi});
  assign c_tgt  = fclamp({20'h00000, wd[11:0]}, {20'h00000, tgt_lo}, {20'h00000, tgt_hi});
  assign c_exp  = fclamp({12'h000, wd[19:0]}, {12'h000, EXP_MIN}, {12'h000, EXP_MAX});

  //////////////////////////////////////////////////////////////////////
  // Register writes and loop updates
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_loop_mode_q      <= `AEGC_MODE_OFF;
      exposure_loop_mode_q  <= `AEGC_MODE_OFF;
      pix12_q               <= 1'b0;
      binning_q             <= `AEGC_BIN_OFF;
      trig_width_q          <= 1'b0;
      gain_tap_select_q     <= `AEGC_TAP_ANALOG;
      profile_q             <= 1'b0;
      lim_off_q             <= 1'b0;
      stats_region_start_q  <= `AEGC_RST_START;
      stats_region_width_q  <= SENSOR_W;
      stats_region_lines_q  <= `AEGC_RST_LINES;
      stats_region_select_q <= `AEGC_RST_SELECT;
      image_start_q         <= `AEGC_RST_START;
      image_width_q         <= SENSOR_W;
      gain_value_q          <= GAIN_LO8;
      auto_gain_min_q       <= GAIN_LO8;
      auto_gain_max_q       <= GAIN_HI;
      target_gray_level_q   <= `AEGC_RST_TARGET;
      exposure_duration_q   <= EXP_RATE;
      auto_exposure_min_q   <= EXP_MIN;
      auto_exposure_max_q   <= EXP_RATE;
      gain_tries_q          <= 5'h00;
      exp_tries_q           <= 5'h00;
      gain_hit_q            <= 1'b0;
      exp_hit_q             <= 1'b0;
      line_rate_reduce_q    <= 1'b0;
    end else begin
      line_rate_reduce_q <= exposure_duration_q > EXP_RATE;
      // Once mode bookkeeping
      if (use_g || (upd && gain_act)) begin
        gain_hit_q <= hit;
        if (gain_loop_mode_q == `AEGC_MODE_ONCE) begin
          if (hit || gain_tries_q == `AEGC_MAX_TRIES - 5'h01) begin
            gain_loop_mode_q <= `AEGC_MODE_OFF;
          end
          gain_tries_q <= gain_tries_q + 5'h01;
        end
      end
      if (upd && exp_act) begin
        exp_hit_q <= hit;
        if (exposure_loop_mode_q == `AEGC_MODE_ONCE) begin
          if (hit || exp_tries_q == `AEGC_MAX_TRIES - 5'h01) begin
            exposure_loop_mode_q <= `AEGC_MODE_OFF;
          end
          exp_tries_q <= exp_tries_q + 5'h01;
        end
      end
      // Automatic values persist when loops stop
      if (use_g) begin
        gain_value_q <= g_new;
      end
      if (use_e) begin
        exposure_duration_q <= e_new;
      end
      // Software writes; gain bounds, target and exposure bounds are clamped, other fields take any value
      if (reg_wr) begin
        case (reg_addr)
          `AEGC_A_CTRL: begin
            gain_loop_mode_q     <= wd[`AEGC_F_GMODE];
            exposure_loop_mode_q <= wd[`AEGC_F_EMODE];
            pix12_q              <= wd[`AEGC_B_PIX12];
            binning_q            <= wd[`AEGC_F_BIN];
            trig_width_q         <= wd[`AEGC_B_TRIGW];
            gain_tap_select_q    <= wd[`AEGC_F_TAP];
            profile_q            <= wd[`AEGC_B_PROFILE];
            lim_off_q            <= wd[`AEGC_B_LIMOFF];
            gain_tries_q         <= 5'h00;
            exp_tries_q          <= 5'h00;
          end
          `AEGC_A_START:   stats_region_start_q  <= wd[X_W-1:0];
          `AEGC_A_WIDTH:   stats_region_width_q  <= wd[X_W-1:0];
          `AEGC_A_LINES:   stats_region_lines_q  <= wd[LINES_W-1:0];
          `AEGC_A_SELECT:  stats_region_select_q <= wd[1:0];
          `AEGC_A_IMSTART: image_start_q         <= wd[X_W-1:0];
          `AEGC_A_IMWIDTH: image_width_q         <= wd[X_W-1:0];
          `AEGC_A_GAIN:    gain_value_q          <= wd[GAIN_W-1:0];
          `AEGC_A_GMIN:    auto_gain_min_q       <= c_gain[GAIN_W-1:0];
          `AEGC_A_GMAX:    auto_gain_max_q       <= c_gain[GAIN_W-1:0];
          `AEGC_A_TARGET:  target_gray_level_q   <= c_tgt[11:0];
          `AEGC_A_EXP: exposure_duration_q <= wd[EXP_W-1:0];
          `AEGC_A_EMIN:    auto_exposure_min_q   <= c_exp[EXP_W-1:0];
          `AEGC_A_EMAX:    auto_exposure_max_q   <= c_exp[EXP_W-1:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AEGC_A_CTRL: reg_rdata_q <= {20'h00000, lim_off_q, profile_q,
          gain_tap_select_q, trig_width_q, binning_q, pix12_q,
          exposure_loop_mode_q, gain_loop_mode_q};
        `AEGC_A_START:   reg_rdata_q <= {19'h00000, stats_region_start_q};
        `AEGC_A_WIDTH:   reg_rdata_q <= {19'h00000, stats_region_width_q};
        `AEGC_A_LINES:   reg_rdata_q <= {16'h0000, stats_region_lines_q};
        `AEGC_A_SELECT:  reg_rdata_q <= {30'h00000000, stats_region_select_q};
        `AEGC_A_IMSTART: reg_rdata_q <= {19'h00000, image_start_q};
        `AEGC_A_IMWIDTH: reg_rdata_q <= {19'h00000, image_width_q};
        `AEGC_A_GAIN:    reg_rdata_q <= {20'h00000, gain_value_q};
        `AEGC_A_GMIN:    reg_rdata_q <= {20'h00000, auto_gain_min_q};
        `AEGC_A_GMAX:    reg_rdata_q <= {20'h00000, auto_gain_max_q};
        `AEGC_A_TARGET:  reg_rdata_q <= {20'h00000, target_gray_level_q};
        `AEGC_A_EXP:     reg_rdata_q <= {12'h000, exposure_duration_q};
        `AEGC_A_EMIN:    reg_rdata_q <= {12'h000, auto_exposure_min_q};
        `AEGC_A_EMAX:    reg_rdata_q <= {12'h000, auto_exposure_max_q};
        `AEGC_A_STATUS: reg_rdata_q <= {st_used, 2'h0, exp_hit_q, gain_hit_q,
          exp_tries_q, gain_tries_q, line_rate_reduce_q, overlap};
        `AEGC_A_LASTCNT: reg_rdata_q <= {3'h0, st_cnt};
        default:         reg_rdata_q <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end

endmodule // aegc_top
`default_nettype wire

// ### verif/aegc_line_src.sv
`timescale 1ns/10ps
`default_nettype none
module aegc_line_src (
  input  wire logic  ref_clk,
  output logic       pix_valid,
  output logic       pix_sol,
  output logic       pix_eol,
  output logic [11:0] pix_data,
  output logic       acq_end
);
  initial begin
    pix_valid = 1'b0;
    pix_sol   = 1'b0;
    pix_eol   = 1'b0;
    pix_data  = 12'hA5A;
    acq_end   = 1'b0;
  end
  // Lines of eight pixels: low half lo, high half hi
  task automatic send(input int n, input logic [11:0] lo, input logic [11:0] hi, input bit stop);
    for (int l = 0; l < n; l++) begin
      for (int p = 0; p < 8; p++) begin
        @(posedge ref_clk);
        pix_valid <= 1'b1;
        pix_sol   <= (p == 0);
        pix_eol   <= (p == 7);
        pix_data  <= (p < 4) ? lo : hi;
      end
      @(posedge ref_clk);
      pix_valid <= 1'b0;
      pix_sol   <= 1'b0;
      pix_eol   <= 1'b0;
      pix_data  <= ~pix_data;
    end
    if (stop) begin
      @(posedge ref_clk);
      acq_end <= 1'b1;
      @(posedge ref_clk);
      acq_end <= 1'b0;
    end
  endtask
endmodule // aegc_line_src
`default_nettype wire

// ### verif/aegc_top_monitor.sv
`include "aegc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module aegc_top_monitor #(
  parameter [19:0] EXP_MIN  = 20'h00002,
  parameter [19:0] EXP_MAX  = 20'hFFFFF,
  parameter [19:0] EXP_STEP = 20'h00001,
  parameter [19:0] EXP_RATE = 20'h00064
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        pix_eol,
  input wire logic        acq_end,
  input wire logic [11:0] gain_value_q,
  input wire logic [19:0] exposure_duration_q,
  input wire logic        line_rate_reduce_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_tgt_rd;
    reg_rd && reg_addr == `AEGC_A_TARGET;
  endsequence
  sequence s_gain_auto;
    $changed(gain_value_q) && !$past(reg_wr);
  endsequence
  sequence s_exp_auto;
    $changed(exposure_duration_q) && !$past(reg_wr);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data outside read slot");
  a_target_range: assert property (s_tgt_rd |=>
    reg_rdata_q >= 32'h32 && reg_rdata_q <= 32'hCD0)
    else $error("target out of range");
  a_gain_step: assert property (s_gain_auto |->
    gain_value_q == $past(gain_value_q) + 12'h001 ||
    gain_value_q == $past(gain_value_q) - 12'h001)
    else $error("gain step wrong");
  a_gain_region_end: assert property (s_gain_auto |->
    $past(pix_eol, 2) || $past(acq_end, 2))
    else $error("gain moved outside region end");
  a_exp_step: assert property (s_exp_auto |->
    exposure_duration_q == $past(exposure_duration_q) + EXP_STEP ||
    exposure_duration_q == $past(exposure_duration_q) - EXP_STEP)
    else $error("exposure step wrong");
  a_exp_region_end: assert property (s_exp_auto |->
    $past(pix_eol, 2) || $past(acq_end, 2))
    else $error("exposure moved outside region end");
  a_exp_limits: assert property (s_exp_auto |->
    exposure_duration_q >= EXP_MIN && exposure_duration_q <= EXP_MAX)
    else $error("exposure outside model range");
  a_rate_flag: assert property (
    line_rate_reduce_q == ($past(exposure_duration_q) > EXP_RATE))
    else $error("line rate flag wrong");
endmodule // aegc_top_monitor
bind aegc_top aegc_top_monitor #(.EXP_MIN(EXP_MIN), .EXP_MAX(EXP_MAX), .EXP_STEP(EXP_STEP),
  .EXP_RATE(EXP_RATE)) u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pix_eol(pix_eol),
  .acq_end(acq_end), .gain_value_q(gain_value_q), .exposure_duration_q(exposure_duration_q),
  .line_rate_reduce_q(line_rate_reduce_q));
`default_nettype wire

// ### verif/tb_auto_gain_exposure_control.sv
`include "aegc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_auto_gain_exposure_control;
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [5:0]  reg_addr  = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata_q;
  logic        pix_valid, pix_sol, pix_eol, acq_end, line_rate_reduce_q;
  logic [11:0] pix_data, gain_value_q;
  logic [19:0] exposure_duration_q;
  int          fail_count = 0;
  int          n_checks   = 0;
  always #2.5 ref_clk = ~ref_clk;
  aegc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pix_valid(pix_valid),
    .pix_sol(pix_sol), .pix_eol(pix_eol), .pix_data(pix_data), .acq_end(acq_end),
    .gain_value_q(gain_value_q), .exposure_duration_q(exposure_duration_q),
    .line_rate_reduce_q(line_rate_reduce_q));
  aegc_line_src SRC (.ref_clk(ref_clk), .pix_valid(pix_valid), .pix_sol(pix_sol),
    .pix_eol(pix_eol), .pix_data(pix_data), .acq_end(acq_end));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata_q);
  endtask
  // n lines, then acq_end if stop, then gain and exposure compared
  task automatic run(input int n, input logic [11:0] lo, input logic [11:0] hi, input bit stop,
                     input logic [31:0] eg, input logic [31:0] ee);
    SRC.send(n, lo, hi, stop);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("gain", eg, {20'h0, gain_value_q});
    chk("exposure", ee, {12'h0, exposure_duration_q});
  endtask
  task automatic summarize;
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`AEGC_A_LINES, 32'h80);
    rd(`AEGC_A_WIDTH, 32'h1000);
    rd(`AEGC_A_START, 32'h0);
    wr(`AEGC_A_WIDTH, 32'h4);
    wr(`AEGC_A_LINES, 32'h2);
    rd(`AEGC_A_LINES, 32'h2);
    wr(`AEGC_A_SELECT, 32'h1);
    wr(`AEGC_A_CTRL, 32'h100);
    wr(`AEGC_A_GAIN, 32'h5);
    wr(`AEGC_A_TARGET, 32'hA);
    rd(`AEGC_A_TARGET, 32'h32);
    wr(`AEGC_A_TARGET, 32'h12C);
    rd(`AEGC_A_TARGET, 32'hCD);
    wr(`AEGC_A_TARGET, 32'h80);
    wr(`AEGC_A_CTRL, 32'h102);
    run(1, 12'h10, 12'hFF, 0, 32'h5, 32'h64);
    run(1, 12'h10, 12'hFF, 0, 32'h6, 32'h64);
    wr(`AEGC_A_START, 32'h4);
    run(2, 12'h10, 12'hFF, 0, 32'h5, 32'h64);
    wr(`AEGC_A_IMSTART, 32'h10);
    run(2, 12'h10, 12'hFF, 0, 32'h5, 32'h64);
    wr(`AEGC_A_IMSTART, 32'h0);
    wr(`AEGC_A_START, 32'h0);
    wr(`AEGC_A_LINES, 32'h1);
    wr(`AEGC_A_CTRL, 32'h101);
    for (int i = 1; i <= 31; i++)
      run(1, 12'h10, 12'hFF, 0, (i > 30) ? 32'h23 : 32'h5 + i, 32'h64);
    rd(`AEGC_A_CTRL, 32'h100);
    wr(`AEGC_A_LINES, 32'h3);
    wr(`AEGC_A_CTRL, 32'h102);
    run(1, 12'h10, 12'hFF, 1, 32'h24, 32'h64);
    wr(`AEGC_A_EMAX, 32'h65);
    wr(`AEGC_A_LINES, 32'h1);
    wr(`AEGC_A_CTRL, 32'h108);
    run(1, 12'h10, 12'h10, 0, 32'h24, 32'h65);
    chk("rate", 32'h1, {31'h0, line_rate_reduce_q});
    run(1, 12'h10, 12'h10, 0, 32'h24, 32'h65);
    wr(`AEGC_A_CTRL, 32'h188);
    run(1, 12'hFF, 12'hFF, 0, 32'h24, 32'h65);
    wr(`AEGC_A_CTRL, 32'h50A);
    run(1, 12'hFF, 12'hFF, 0, 32'h23, 32'h65);
    wr(`AEGC_A_CTRL, 32'h10A);
    run(1, 12'hFF, 12'hFF, 0, 32'h23, 32'h64);
    wr(`AEGC_A_GMAX, 32'hFFF);
    rd(`AEGC_A_GMAX, 32'h3FF);
    wr(`AEGC_A_CTRL, 32'h020);
    wr(`AEGC_A_GMAX, 32'hFFF);
    rd(`AEGC_A_GMAX, 32'h1FF);
    wr(`AEGC_A_CTRL, 32'h800);
    wr(`AEGC_A_GMAX, 32'hFFF);
    rd(`AEGC_A_GMAX, 32'hFFF);
    wr(`AEGC_A_CTRL, 32'h110);
    wr(`AEGC_A_TARGET, 32'h64);
    rd(`AEGC_A_TARGET, 32'h320);
    wr(`AEGC_A_TARGET, 32'hFA0);
    rd(`AEGC_A_TARGET, 32'hCD0);
    summarize();
  end
endmodule // tb_auto_gain_exposure_control
`default_nettype wire
